// ===== rtl/boundary_memory_protect_trap.v
// Boundary memory protection trap unit top level
`timescale 1ns/1ps
`include "mem_protect_consts.vh"
// Behaviour
// - Lower memory protected in 2000-octal blocks
// - User mode checks and traps each instruction
// - Trap forces call to 20 or 0
// - Missing memory bank reference causes trap in user mode, memory restart otherwise
// - Enter user mode by command or console
// - Protect switch ignored once program runs
// - I/O reset clears boundary and user mode
// - Lamps show flags, mode, boundary bits
// - Skip command when missing-bank flag set
// - Violation flag set; skip command tests it
// - User mode starts after next non-IO_TRANSFER_INSTRUCTION instruction
// - Separate clears for each flag
// - Load boundary from accumulator bits 3-7
// - Saved word written at trap target
// - Protected when address bits below boundary
// - Illegal: IO_TRANSFER_INSTRUCTION, switch-OR, halt, execute chains
// - Trap sets violation, exits user, forces 33
// - Saved word bit 2 holds user mode
module boundary_memory_protect_trap
(
    // Clock and reset
    input wire i_mclk,
    input wire i_arst_n,
    // Processor instruction check
    input wire i_instr_valid,
    input wire [17:0] i_instr,
    input wire i_ref_valid,
    input wire [14:0] i_ref_addr,
    input wire i_instr_done,
    input wire i_xct_chain,
    input wire i_pi_enabled,
    input wire i_save_state,
    input wire i_cal,
    // Memory cycle monitoring
    input wire i_mem_start,
    input wire i_mem_strobe,
    input wire i_mem_check,
    // I/O bus
    input wire i_iot_pulse,
    input wire [17:0] i_accumulator,
    input wire i_io_reset,
    // Console
    input wire i_console_protect_switch,
    input wire i_console_start,
    // Trap and skip outputs
    output wire o_trap,
    output reg [14:0] o_trap_target,
    output wire [14:0] o_forced_ma,
    output wire o_skip_request,
    output wire o_save_user_bit,
    output wire o_mem_restart,
    // Lamps
    output wire o_violation_lamp,
    output wire o_missing_bank_lamp,
    output wire o_user_mode_lamp,
    output wire [4:0] o_boundary_lamps
);
    reg [4:0] protected_block_limit;
    reg user_mode;
    reg pre_user_mode;
    reg violation_flag;
    reg missing_bank_flag;
    reg mem_ok;
    reg start_seen;
    reg trap_q;
    wire protect_sw;
    wire start_key;
    wire ref_protected;
    wire opc_is_iot;
    wire is_illegal;
    wire is_missing;
    wire trap_now;
    wire cmd_skip_missing;
    wire cmd_skip_viol;
    wire cmd_enter_user;
    wire cmd_clear_viol;
    wire cmd_clear_missing;
    wire cmd_load_bound;

    function cmd_match;
        input [17:0] word;
        input [17:0] code;
        begin
            cmd_match = (word == code);
        end
    endfunction

    prot_sync u_sync_sw
    (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_async(i_console_protect_switch),
        .o_level(protect_sw)
    );

    prot_sync u_sync_start
    (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_async(i_console_start),
        .o_level(start_key)
    );

    prot_compare u_cmp
    (
        .i_addr(i_ref_addr),
        .i_bound(protected_block_limit),
        .o_protected(ref_protected)
    );

    // Command decode on the I/O transfer pulse
    assign cmd_skip_missing = i_iot_pulse && cmd_match(i_instr, `IOT_SKIP_MISSING);
    assign cmd_skip_viol = i_iot_pulse && cmd_match(i_instr, `IOT_SKIP_VIOL);
    assign cmd_enter_user = i_iot_pulse && cmd_match(i_instr, `IOT_ENTER_USER);
    assign cmd_clear_viol = i_iot_pulse && cmd_match(i_instr, `IOT_CLEAR_VIOL);
    assign cmd_clear_missing = i_iot_pulse && cmd_match(i_instr, `IOT_CLEAR_MISSING);
    assign cmd_load_bound = i_iot_pulse && cmd_match(i_instr, `IOT_LOAD_BOUND);

    assign opc_is_iot = (i_instr[17:14] == `OPC_IOT);
    // Illegal class decode
    assign is_illegal = opc_is_iot || i_xct_chain ||
        ((i_instr[17:14] == `OPC_OPR) &&
         (i_instr[`OPR_HLT_BIT] || i_instr[`OPR_OAS_BIT]));
    assign is_missing = mem_ok && i_mem_check;

    // Trap condition while user mode is active
    // Missing bank is caught at check time, with or without an instruction strobe
    assign trap_now = user_mode && !i_cal &&
        ((i_instr_valid && (is_illegal || (i_ref_valid && ref_protected))) ||
         is_missing);

    assign o_trap = trap_q;
    assign o_forced_ma = trap_q ? `TRAP_MA_FORCE : 15'h0000;
    assign o_skip_request = (cmd_skip_missing && missing_bank_flag) ||
        (cmd_skip_viol && violation_flag);
    assign o_save_user_bit = i_save_state && user_mode;
    assign o_mem_restart = is_missing && !user_mode;
    // Lamps
    assign o_violation_lamp = violation_flag;
    assign o_missing_bank_lamp = missing_bank_flag;
    assign o_user_mode_lamp = user_mode;
    assign o_boundary_lamps = protected_block_limit;

    always @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            protected_block_limit <= `BOUND_RESET;
            user_mode <= 1'b0;
            pre_user_mode <= 1'b0;
            violation_flag <= 1'b0;
            missing_bank_flag <= 1'b0;
            mem_ok <= 1'b0;
            start_seen <= 1'b0;
            trap_q <= 1'b0;
            o_trap_target <= `TRAP_ADDR_NO_PI;
        end
        else if (i_io_reset)
        begin
            protected_block_limit <= `BOUND_RESET;
            user_mode <= 1'b0;
            pre_user_mode <= 1'b0;
            violation_flag <= 1'b0;
            missing_bank_flag <= 1'b0;
            mem_ok <= 1'b0;
            trap_q <= 1'b0;
            start_seen <= start_key;
        end
        else
        begin
            start_seen <= start_key;
            trap_q <= trap_now;
            if (trap_now)
                o_trap_target <= i_pi_enabled ? `TRAP_ADDR_PI : `TRAP_ADDR_NO_PI;
            // Memory cycle watch: start sets, strobe or check clears
            if (i_mem_start)
                mem_ok <= 1'b1;
            else if (i_mem_strobe || i_mem_check)
                mem_ok <= 1'b0;
            if (is_missing)
                missing_bank_flag <= 1'b1;
            else if (cmd_clear_missing)
                missing_bank_flag <= 1'b0;
            if (trap_now)
                violation_flag <= 1'b1;
            else if (cmd_clear_viol)
                violation_flag <= 1'b0;
            if (cmd_load_bound)
                protected_block_limit <=
                    i_accumulator[17-`BOUND_MSB_BIT:17-`BOUND_LSB_BIT];
            // User mode control
            if (trap_now || (i_cal && i_instr_valid))
            begin
                user_mode <= 1'b0;
                pre_user_mode <= 1'b0;
            end
            else if (cmd_enter_user)
                pre_user_mode <= 1'b1;
            else if (pre_user_mode && i_instr_done && !opc_is_iot)
            begin
                user_mode <= 1'b1;
                pre_user_mode <= 1'b0;
            end
            else if (start_key && !start_seen && protect_sw)
                user_mode <= 1'b1;
        end
    end
endmodule

// ===== rtl/mem_protect_consts.vh
// Constants for the boundary memory protection trap unit
`ifndef MEM_PROTECT_CONSTS_VH
`define MEM_PROTECT_CONSTS_VH
`define IOT_SKIP_MISSING 18'h383e1
`define IOT_SKIP_VIOL 18'h383c1
`define IOT_ENTER_USER 18'h383e2
`define IOT_CLEAR_VIOL 18'h383c2
`define IOT_CLEAR_MISSING 18'h383d2
`define IOT_LOAD_BOUND 18'h383c4
`define OPC_IOT 4'he
`define OPC_XCT 4'h4
`define OPC_OPR 4'hf
`define OPC_JMS 4'h8
`define OPC_CAL 4'h0
`define OPR_HLT_BIT 9
`define OPR_OAS_BIT 8
`define TRAP_ADDR_NO_PI 15'h0010
`define TRAP_ADDR_PI 15'h0000
`define TRAP_MA_FORCE 15'h001b
`define SAVE_USER_BIT 2
`define BOUND_MSB_BIT 3
`define BOUND_LSB_BIT 7
`define BOUND_RESET 5'h00
`endif

// ===== rtl/prot_sync.v
// Three-stage synchroniser with agreement filter for console inputs
`timescale 1ns/1ps
module prot_sync
(
    // Clock and reset
    input wire i_mclk,
    input wire i_arst_n,
    // Asynchronous input
    input wire i_async,
    // Filtered level
    output reg o_level
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                o_level <= s3;
        end
    end
endmodule

// ===== rtl/prot_compare.v
// Protected region comparator
`timescale 1ns/1ps
module prot_compare
(
    // Address and boundary
    input wire [14:0] i_addr,
    input wire [4:0] i_bound,
    // Result
    output wire o_protected
);
    // Address bits 3..7 of the 18-bit word are bits 14..10 of a 15-bit address
    assign o_protected = (i_addr[14:10] < i_bound);
endmodule

// ===== dv/pchk_asserts.sv
// Port checker for the protection trap unit
`timescale 1ns/1ps
`include "mem_protect_consts.vh"
module pchk
(
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_iot_pulse,
    input wire [17:0] i_instr,
    input wire i_io_reset,
    input wire i_save_state,
    input wire o_trap,
    input wire [14:0] o_forced_ma,
    input wire o_skip_request,
    input wire o_save_user_bit,
    input wire o_violation_lamp,
    input wire o_missing_bank_lamp,
    input wire o_user_mode_lamp,
    input wire [4:0] o_boundary_lamps
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    sequence s_cmd(c);
        i_iot_pulse && i_instr == c;
    endsequence
    sequence s_exit;
        o_violation_lamp && !o_user_mode_lamp;
    endsequence
    AST_MA: assert property (o_trap |-> o_forced_ma == 15'h001b)
        else $error("ma");
    AST_EXIT: assert property (o_trap |-> s_exit)
        else $error("exit");
    AST_USER: assert property (o_trap |-> $past(o_user_mode_lamp))
        else $error("user");
    AST_VKEEP: assert property (o_violation_lamp && !i_io_reset
        && !(i_iot_pulse && i_instr == `IOT_CLEAR_VIOL) |=> o_violation_lamp) else $error("v");
    AST_MKEEP: assert property (o_missing_bank_lamp && !i_io_reset
        && !(i_iot_pulse && i_instr == `IOT_CLEAR_MISSING) |=> o_missing_bank_lamp)
        else $error("m");
    AST_SKV: assert property (s_cmd(`IOT_SKIP_VIOL) |-> o_skip_request == o_violation_lamp)
        else $error("skv");
    AST_SKM: assert property (s_cmd(`IOT_SKIP_MISSING)
        |-> o_skip_request == o_missing_bank_lamp) else $error("skm");
    AST_IORST: assert property (i_io_reset |=> o_boundary_lamps == 5'h00 && !o_user_mode_lamp)
        else $error("io");
    AST_SAVE: assert property (o_save_user_bit == (i_save_state && o_user_mode_lamp))
        else $error("save");
endmodule

// ===== dv/cpu_model.sv
// Processor and memory control model
`timescale 1ns/1ps
module cpu_model
(
    input wire i_mclk,
    input wire i_trap,
    input wire [14:0] i_target,
    input wire i_skip,
    output reg o_valid = 1'b0,
    output reg [17:0] o_instr = 18'h00000,
    output reg o_ref = 1'b0,
    output reg [14:0] o_addr = 15'h0000,
    output reg o_iot = 1'b0,
    output reg o_start = 1'b0,
    output reg o_strobe = 1'b0,
    output reg o_check = 1'b0,
    output reg [14:0] o_jms = 15'h0000
);
    // Forced call lands where the unit points, where the saved word goes
    always @(posedge i_mclk)
        if (i_trap)
            o_jms <= i_target;
    task exec(input [17:0] w, input r, input [14:0] a);
        @(posedge i_mclk);
        o_valid <= 1'b1;
        o_instr <= w;
        o_ref <= r;
        o_addr <= a;
        @(posedge i_mclk);
        o_valid <= 1'b0;
        o_addr <= ~a;
    endtask
    task io_transfer_instruction(input [17:0] c, output s);
        @(posedge i_mclk);
        o_instr <= c;
        o_iot <= 1'b1;
        @(negedge i_mclk);
        s = i_skip;
        @(posedge i_mclk);
        o_iot <= 1'b0;
    endtask
    task mem(input hit);
        @(posedge i_mclk);
        o_start <= 1'b1;
        @(posedge i_mclk);
        o_start <= 1'b0;
        o_strobe <= hit;
        @(posedge i_mclk);
        o_strobe <= 1'b0;
        o_check <= 1'b1;
        @(posedge i_mclk);
        o_check <= 1'b0;
    endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the protection trap unit
`timescale 1ns/1ps
`include "mem_protect_consts.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
    reg i_mclk = 0, i_arst_n = 0, i_xct_chain = 0, i_pi_enabled = 0, i_save_state = 0, i_cal = 0;
    reg i_io_reset = 0, i_console_protect_switch = 0, i_console_start = 0, s;
    reg [17:0] i_accumulator = 0;
    wire i_instr_valid, i_ref_valid, i_iot_pulse, i_mem_start, i_mem_strobe, i_mem_check, o_trap;
    wire o_skip_request, o_save_user_bit, o_mem_restart, o_violation_lamp, o_missing_bank_lamp;
    wire o_user_mode_lamp;
    wire [17:0] i_instr;
    wire [14:0] i_ref_addr, o_trap_target, o_forced_ma;
    wire [4:0] o_boundary_lamps;
    integer errors = 0, comparisons = 0, i;
    reg [17:0] ill [0:3] = '{18'h3c200, 18'h3c100, 18'h38000, 18'h10000};
    initial forever #4 i_mclk = ~i_mclk;
    cpu_model u_cpu_model (.i_mclk, .i_trap(o_trap), .i_target(o_trap_target),
        .i_skip(o_skip_request), .o_valid(i_instr_valid), .o_instr(i_instr), .o_ref(i_ref_valid),
        .o_addr(i_ref_addr), .o_iot(i_iot_pulse), .o_start(i_mem_start), .o_strobe(i_mem_strobe),
        .o_check(i_mem_check), .o_jms());
    boundary_memory_protect_trap u_boundary_memory_protect_trap (.i_mclk, .i_arst_n,
        .i_instr_valid, .i_instr, .i_ref_valid, .i_ref_addr, .i_instr_done(i_instr_valid),
        .i_xct_chain, .i_pi_enabled, .i_save_state, .i_cal, .i_mem_start, .i_mem_strobe,
        .i_mem_check, .i_iot_pulse, .i_accumulator, .i_io_reset, .i_console_protect_switch,
        .i_console_start, .o_trap, .o_trap_target, .o_forced_ma, .o_skip_request, .o_save_user_bit,
        .o_mem_restart, .o_violation_lamp, .o_missing_bank_lamp, .o_user_mode_lamp,
        .o_boundary_lamps);
    task conclude;
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task t_user;
        u_cpu_model.io_transfer_instruction(`IOT_ENTER_USER, s);
        u_cpu_model.exec(18'h38000, 0, 0);
        @(negedge i_mclk);
        `CHK("pre", 1'b0, o_user_mode_lamp)
        u_cpu_model.exec(18'h08000, 0, 0);
        @(negedge i_mclk);
        `CHK("user", 1'b1, o_user_mode_lamp)
        i_save_state <= 1'b1;
        @(negedge i_mclk);
        `CHK("save", 1'b1, o_save_user_bit)
        i_save_state <= 1'b0;
    endtask
    task t_trap;
        i_accumulator <= 18'h02800;
        u_cpu_model.io_transfer_instruction(`IOT_LOAD_BOUND, s);
        @(negedge i_mclk);
        `CHK("bound", 5'h0a, o_boundary_lamps)
        t_user;
        u_cpu_model.exec(18'h08000, 1, 15'h2800);
        @(negedge i_mclk);
        `CHK("edge", 1'b0, o_trap)
        u_cpu_model.exec(18'h08000, 1, 15'h2400);
        @(negedge i_mclk);
        `CHK("trap", 1'b1, o_trap)
    endtask
    task t_illegal;
        for (i = 0; i < 4; i++)
        begin
            t_user;
            i_pi_enabled <= i[0];
            i_xct_chain <= (i == 3);
            u_cpu_model.exec(ill[i], 0, 0);
            @(negedge i_mclk);
            `CHK("ill", 1'b1, o_trap)
            @(negedge i_mclk);
            `CHK("tgt", i[0] ? 15'h0000 : 15'h0010, u_cpu_model.o_jms)
        end
        i_xct_chain <= 1'b0;
    endtask
    task t_flags;
        u_cpu_model.io_transfer_instruction(`IOT_CLEAR_MISSING, s);
        u_cpu_model.io_transfer_instruction(`IOT_SKIP_VIOL, s);
        `CHK("keep", 1'b1, s)
        u_cpu_model.io_transfer_instruction(`IOT_CLEAR_VIOL, s);
        u_cpu_model.io_transfer_instruction(`IOT_SKIP_VIOL, s);
        `CHK("clr", 1'b0, s)
        u_cpu_model.mem(1);
        u_cpu_model.io_transfer_instruction(`IOT_SKIP_MISSING, s);
        `CHK("hit", 1'b0, s)
        u_cpu_model.mem(0);
        u_cpu_model.io_transfer_instruction(`IOT_SKIP_MISSING, s);
        `CHK("miss", 1'b1, s)
        t_user;
        u_cpu_model.mem(0);
        repeat (2) @(negedge i_mclk);
        `CHK("mtrap", 1'b1, o_violation_lamp)
    endtask
    task t_console;
        t_user;
        i_io_reset <= 1'b1;
        @(posedge i_mclk);
        i_io_reset <= 1'b0;
        i_console_protect_switch <= 1'b1;
        i_console_start <= 1'b1;
        @(negedge i_mclk);
        `CHK("iob", 5'h00, o_boundary_lamps)
        `CHK("iou", 1'b0, o_user_mode_lamp)
        repeat (8) @(posedge i_mclk);
        i_console_start <= 1'b0;
        repeat (8) @(negedge i_mclk);
        `CHK("con", 1'b1, o_user_mode_lamp)
        i_console_protect_switch <= 1'b0;
        repeat (8) @(negedge i_mclk);
        `CHK("sw", 1'b1, o_user_mode_lamp)
    endtask
    initial
    begin
        repeat (4) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        t_trap;
        t_illegal;
        t_flags;
        t_console;
        conclude;
    end
    initial
    begin
        repeat (3000) @(posedge i_mclk);
        errors++;
        conclude;
    end
endmodule
bind boundary_memory_protect_trap pchk u_pchk (.i_mclk, .i_arst_n, .i_iot_pulse, .i_instr,
    .i_io_reset, .i_save_state, .o_trap, .o_forced_ma, .o_skip_request, .o_save_user_bit,
    .o_violation_lamp, .o_missing_bank_lamp, .o_user_mode_lamp, .o_boundary_lamps);
